// >>> acs_pkg.sv
package acs_pkg;

  // bus and data widths
  localparam int ACS_AW = 10;
  localparam int ACS_DW = 16;
  localparam int ACS_RW = 8;
  localparam int ACS_RES_W = 10;
  localparam int ACS_NCH = 8;
  localparam int ACS_CH_W = 3;

  // register addresses
  localparam logic [ACS_AW-1:0] ACS_CTRL0_ADDR = 10'h3D6;
  localparam logic [ACS_AW-1:0] ACS_CTRL1_ADDR = 10'h3D7;
  localparam logic [ACS_AW-1:0] ACS_CTRL2_ADDR = 10'h3D4;
  localparam logic [ACS_AW-1:0] ACS_RES_BASE = 10'h3C0;
  localparam int ACS_RES_HI = 4;

  // converter_control_zero fields
  localparam int ACS_CH_LSB = 0;
  localparam int ACS_MODE_LSB = 3;
  localparam int ACS_TRG_BIT = 5;
  localparam int ACS_START_BIT = 6;
  localparam int ACS_CLOCK_DIVIDER_BIT0_BIT = 7;

  // converter_control_one fields
  localparam int ACS_SWEEP_LSB = 0;
  localparam int ACS_EXT_LSB = 2;
  localparam int ACS_REFERENCE_CONNECT_BIT_BIT = 5;

  // converter_control_two fields
  localparam int ACS_SMP_BIT = 0;
  localparam int ACS_GRP_LSB = 1;
  localparam int ACS_RSV_BIT = 3;
  localparam int ACS_CKS2_BIT = 4;

  // reset values, sweep step and extended-input result slots
  localparam logic [ACS_CH_W-1:0] ACS_CH_RST = 3'h0;
  localparam logic [1:0] ACS_FIELD2_RST = 2'h0;
  localparam logic ACS_BIT_RST = 1'b0;
  localparam logic [ACS_CH_W-1:0] ACS_POS_FIRST = 3'h0;
  localparam logic [ACS_CH_W-1:0] ACS_POS_STEP = 3'h1;
  localparam logic [ACS_CH_W-1:0] ACS_EXT0_SLOT = 3'h0;
  localparam logic [ACS_CH_W-1:0] ACS_EXT1_SLOT = 3'h1;

  typedef enum logic [1:0] {
    ACS_MODE_ONESHOT = 2'b00,
    ACS_MODE_REPEAT = 2'b01,
    ACS_MODE_SSWEEP = 2'b10,
    ACS_MODE_RSWEEP = 2'b11
  } acs_mode_t;

  typedef enum logic [1:0] {
    ACS_EXT_NONE = 2'b00,
    ACS_EXT_ZERO = 2'b01,
    ACS_EXT_ONE = 2'b10,
    ACS_EXT_OPAMP = 2'b11
  } acs_ext_t;

  typedef enum logic [1:0] {
    ACS_GRP_FIRST = 2'b00,
    ACS_GRP_BAD = 2'b01,
    ACS_GRP_SECOND = 2'b10,
    ACS_GRP_THIRD = 2'b11
  } acs_grp_t;

  typedef enum logic [1:0] {
    ACS_ST_IDLE = 2'b00,
    ACS_ST_ARMED = 2'b01,
    ACS_ST_ISSUE = 2'b10,
    ACS_ST_CONV = 2'b11
  } acs_state_t;

endpackage

// >>> acs_sync.sv
`timescale 1ns/100ps
module acs_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // level in and out
  input wire logic async_i,
  output logic sync_o
);

  logic meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

// >>> acs_sequencer.sv
// What this block does
// - repeat mode reconverts one channel endlessly
// - software start begins conversion at once
// - external trigger: falling edge after start set
// - repeat modes stop only on clear, no irq
// - single sweep converts each channel once
// - sweep end raises irq, clears soft start
// - sweep set is first 2/4/6/8 channels
// - repeat sweep cycles channels until halted
// - repeat picks any group input or extended
// - channel field picks input zero to seven
// - mode field 01 selects repeat mode
// - group field selects equivalent input group
// - result goes to matching result register
// - group field 00/10/11, 01 forbidden
// - mode field 00 selects one-shot
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module acs_sequencer
  import acs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [ACS_AW-1:0] addr_i,
  input wire logic [ACS_DW-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [ACS_DW-1:0] rd_data_o,
  // external trigger pin, active falling edge
  input wire logic ext_trig_n_i,
  // analog converter core
  output logic conv_start_o,
  output logic [ACS_CH_W-1:0] chan_sel_o,
  output logic [1:0] group_sel_o,
  output logic [1:0] ext_sel_o,
  input wire logic conv_done_i,
  input wire logic [ACS_RES_W-1:0] conv_data_i,
  // status and analog controls
  output logic ref_connect_o,
  output logic hold_en_o,
  output logic busy_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // control state

  logic [ACS_CH_W-1:0] ch_reg;
  acs_mode_t mode_reg;
  logic trg_reg;
  logic start_reg;
  logic clock_divider_bit0_reg;
  logic [1:0] sweep_reg;
  acs_ext_t ext_reg;
  logic rsv_reg;
  logic cks2_reg;
  acs_state_t state_reg;
  acs_state_t state_next;
  logic [ACS_CH_W-1:0] pos_reg;
  logic [ACS_CH_W-1:0] pos_next;
  logic [ACS_CH_W-1:0] res_idx_reg;
  logic [ACS_RES_W-1:0] res_mem [ACS_NCH];
  logic trig_s;
  logic trig_d_reg;
  logic trig_fall;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_ctrl2;
  logic res_hit;
  logic sweep_mode;
  logic ext_used;
  logic [ACS_CH_W-1:0] last_pos;
  logic retrig;
  logic store;
  logic finish;
  logic [ACS_RW-1:0] ctrl0_rd;
  logic [ACS_RW-1:0] ctrl1_rd;
  logic [ACS_RW-1:0] ctrl2_rd;
  logic [ACS_CH_W-1:0] conv_ch;
  logic [ACS_CH_W-1:0] conv_slot;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  always_comb begin
    wr_ctrl0 = 1'b0;
    wr_ctrl1 = 1'b0;
    wr_ctrl2 = 1'b0;
    if (addr_i == ACS_CTRL0_ADDR) begin
      wr_ctrl0 = wr_en_i;
    end else if (addr_i == ACS_CTRL1_ADDR) begin
      wr_ctrl1 = wr_en_i;
    end else if (addr_i == ACS_CTRL2_ADDR) begin
      wr_ctrl2 = wr_en_i;
    end
  end

  assign res_hit = (addr_i[ACS_AW-1:ACS_RES_HI] ==
                    ACS_RES_BASE[ACS_AW-1:ACS_RES_HI]) && !addr_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // trigger pin

  acs_sync #(
    .RST_VAL(1'b1)
  ) u_trig_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .async_i(ext_trig_n_i),
    .sync_o(trig_s)
  );

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_d_reg <= 1'b1;
    end else begin
      trig_d_reg <= trig_s;
    end
  end

  assign trig_fall = trig_d_reg && !trig_s;

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ch_reg <= ACS_CH_RST;
      mode_reg <= ACS_MODE_ONESHOT;
      trg_reg <= ACS_BIT_RST;
      clock_divider_bit0_reg <= ACS_BIT_RST;
    end else if (wr_ctrl0) begin
      ch_reg <= wr_data_i[ACS_CH_LSB +: ACS_CH_W];
      mode_reg <= acs_mode_t'(wr_data_i[ACS_MODE_LSB +: 2]);
      trg_reg <= wr_data_i[ACS_TRG_BIT];
      clock_divider_bit0_reg <= wr_data_i[ACS_CLOCK_DIVIDER_BIT0_BIT];
    end
  end

  // a software write wins over the hardware clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_reg <= ACS_BIT_RST;
    end else if (wr_ctrl0) begin
      start_reg <= wr_data_i[ACS_START_BIT];
    end else if (finish && !trg_reg) begin
      start_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sweep_reg <= ACS_FIELD2_RST;
      ext_reg <= ACS_EXT_NONE;
      ref_connect_o <= ACS_BIT_RST;
    end else if (wr_ctrl1) begin
      sweep_reg <= wr_data_i[ACS_SWEEP_LSB +: 2];
      ext_reg <= acs_ext_t'(wr_data_i[ACS_EXT_LSB +: 2]);
      // reference stays connected while a conversion is enabled
      if (wr_data_i[ACS_REFERENCE_CONNECT_BIT_BIT] || !start_reg) begin
        ref_connect_o <= wr_data_i[ACS_REFERENCE_CONNECT_BIT_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      group_sel_o <= ACS_GRP_FIRST;
      hold_en_o <= ACS_BIT_RST;
      rsv_reg <= ACS_BIT_RST;
      cks2_reg <= ACS_BIT_RST;
    end else if (wr_ctrl2) begin
      // forbidden group code keeps the previous group
      if (wr_data_i[ACS_GRP_LSB +: 2] != ACS_GRP_BAD) begin
        group_sel_o <= wr_data_i[ACS_GRP_LSB +: 2];
      end
      hold_en_o <= wr_data_i[ACS_SMP_BIT];
      rsv_reg <= wr_data_i[ACS_RSV_BIT];
      cks2_reg <= wr_data_i[ACS_CKS2_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  assign sweep_mode = mode_reg[1];
  assign last_pos = {sweep_reg, 1'b1};
  assign ext_used = !sweep_mode &&
                    (ext_reg == ACS_EXT_ZERO || ext_reg == ACS_EXT_ONE);
  assign retrig = trg_reg && trig_fall;
  assign store = (state_reg == ACS_ST_CONV) && conv_done_i && start_reg;
  assign finish = store && !retrig &&
                  (mode_reg == ACS_MODE_ONESHOT ||
                   (mode_reg == ACS_MODE_SSWEEP && pos_reg == last_pos));
  assign conv_ch = sweep_mode ? pos_reg : ch_reg;
  assign conv_slot = !ext_used ? conv_ch :
                     (ext_reg == ACS_EXT_ONE) ? ACS_EXT1_SLOT : ACS_EXT0_SLOT;

  always_comb begin
    state_next = state_reg;
    pos_next = pos_reg;
    case (state_reg)
      ACS_ST_IDLE: begin
        if (start_reg) begin
          state_next = trg_reg ? ACS_ST_ARMED : ACS_ST_ISSUE;
          pos_next = ACS_POS_FIRST;
        end
      end
      ACS_ST_ARMED: begin
        if (trig_fall) begin
          state_next = ACS_ST_ISSUE;
          pos_next = ACS_POS_FIRST;
        end
      end
      ACS_ST_ISSUE: begin
        state_next = ACS_ST_CONV;
      end
      ACS_ST_CONV: begin
        if (retrig) begin
          state_next = ACS_ST_ISSUE;
          pos_next = ACS_POS_FIRST;
        end else if (finish) begin
          state_next = trg_reg ? ACS_ST_ARMED : ACS_ST_IDLE;
          pos_next = ACS_POS_FIRST;
        end else if (conv_done_i) begin
          state_next = ACS_ST_ISSUE;
          if (sweep_mode) begin
            // ascending order, wrap after the last channel of the set
            pos_next = (pos_reg == last_pos) ? ACS_POS_FIRST :
                       pos_reg + ACS_POS_STEP;
          end
        end
      end
      default: begin
        state_next = ACS_ST_IDLE;
      end
    endcase
    if (!start_reg) begin
      state_next = ACS_ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ACS_ST_IDLE;
      pos_reg <= ACS_POS_FIRST;
      busy_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      pos_reg <= pos_next;
      busy_o <= (state_next == ACS_ST_ISSUE) || (state_next == ACS_ST_CONV);
    end
  end

  // channel steering latched as each conversion is issued
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_start_o <= 1'b0;
      chan_sel_o <= ACS_CH_RST;
      ext_sel_o <= ACS_EXT_NONE;
      res_idx_reg <= ACS_POS_FIRST;
    end else begin
      conv_start_o <= (state_reg == ACS_ST_ISSUE) && start_reg;
      if (state_reg == ACS_ST_ISSUE) begin
        chan_sel_o <= conv_ch;
        ext_sel_o <= ext_used ? ext_reg : ACS_EXT_NONE;
        res_idx_reg <= conv_slot;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= finish;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result registers and read port

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < ACS_NCH; i++) begin
        res_mem[i] <= '0;
      end
    end else if (store) begin
      res_mem[res_idx_reg] <= conv_data_i;
    end
  end

  always_comb begin
    ctrl0_rd = '0;
    ctrl0_rd[ACS_CH_LSB +: ACS_CH_W] = ch_reg;
    ctrl0_rd[ACS_MODE_LSB +: 2] = mode_reg;
    ctrl0_rd[ACS_TRG_BIT] = trg_reg;
    ctrl0_rd[ACS_START_BIT] = start_reg;
    ctrl0_rd[ACS_CLOCK_DIVIDER_BIT0_BIT] = clock_divider_bit0_reg;
    ctrl1_rd = '0;
    ctrl1_rd[ACS_SWEEP_LSB +: 2] = sweep_reg;
    ctrl1_rd[ACS_EXT_LSB +: 2] = ext_reg;
    ctrl1_rd[ACS_REFERENCE_CONNECT_BIT_BIT] = ref_connect_o;
    ctrl2_rd = '0;
    ctrl2_rd[ACS_SMP_BIT] = hold_en_o;
    ctrl2_rd[ACS_GRP_LSB +: 2] = group_sel_o;
    ctrl2_rd[ACS_RSV_BIT] = rsv_reg;
    ctrl2_rd[ACS_CKS2_BIT] = cks2_reg;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= '0;
    end else if (!rd_en_i) begin
      rd_data_o <= '0;
    end else if (addr_i == ACS_CTRL0_ADDR) begin
      rd_data_o <= {{(ACS_DW-ACS_RW){1'b0}}, ctrl0_rd};
    end else if (addr_i == ACS_CTRL1_ADDR) begin
      rd_data_o <= {{(ACS_DW-ACS_RW){1'b0}}, ctrl1_rd};
    end else if (addr_i == ACS_CTRL2_ADDR) begin
      rd_data_o <= {{(ACS_DW-ACS_RW){1'b0}}, ctrl2_rd};
    end else if (res_hit) begin
      rd_data_o <= {{(ACS_DW-ACS_RES_W){1'b0}},
                    res_mem[addr_i[ACS_CH_W:1]]};
    end else begin
      rd_data_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_issue;
    state_reg == ACS_ST_ISSUE ##1 conv_start_o;
  endsequence

  property p_repeat_loop;
    (store && !retrig && mode_reg == ACS_MODE_REPEAT && !wr_ctrl0)
      |=> (!irq_o) and s_issue;
  endproperty
  a_repeat_loop: assert property (p_repeat_loop)
    else $error("repeat mode did not reissue or raised irq");

  property p_sw_start;
    (wr_ctrl0 && wr_data_i[ACS_START_BIT] && !wr_data_i[ACS_TRG_BIT] &&
     state_reg == ACS_ST_IDLE && !start_reg)
      ##1 (!wr_ctrl0 [*2]) |=> conv_start_o;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("software start did not start a conversion");

  property p_ext_wait;
    (state_reg == ACS_ST_ARMED && !trig_fall) |=> state_reg != ACS_ST_ISSUE;
  endproperty
  a_ext_wait: assert property (p_ext_wait)
    else $error("conversion began without a trigger edge");

  property p_ext_go;
    (state_reg == ACS_ST_ARMED && trig_fall && start_reg && !wr_ctrl0)
      |=> s_issue;
  endproperty
  a_ext_go: assert property (p_ext_go)
    else $error("trigger edge did not start a conversion");

  property p_stop;
    !start_reg |=> state_reg == ACS_ST_IDLE && !conv_start_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("sequencer kept running after start flag cleared");

  property p_sweep_end;
    (store && !retrig && mode_reg == ACS_MODE_SSWEEP &&
     pos_reg == last_pos && !trg_reg && !wr_ctrl0)
      |=> irq_o && !start_reg ##1 !irq_o;
  endproperty
  a_sweep_end: assert property (p_sweep_end)
    else $error("sweep end did not pulse irq and clear start");

  property p_wrap;
    (store && !retrig && mode_reg == ACS_MODE_RSWEEP &&
     pos_reg == last_pos && !wr_ctrl0)
      |=> pos_reg == ACS_POS_FIRST && !irq_o;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("repeat sweep did not wrap to the first channel");

  property p_result;
    store |=> res_mem[$past(res_idx_reg)] == $past(conv_data_i);
  endproperty
  a_result: assert property (p_result)
    else $error("result not stored at its channel slot");

  property p_chan;
    (state_reg == ACS_ST_ISSUE && !sweep_mode && !ext_used)
      |=> chan_sel_o == $past(ch_reg);
  endproperty
  a_chan: assert property (p_chan)
    else $error("converted channel differs from channel field");

  property p_group;
    group_sel_o != ACS_GRP_BAD;
  endproperty
  a_group: assert property (p_group)
    else $error("forbidden group code reached the multiplexer");

endmodule

// >>> acs_core_model.sv
`timescale 1ns/100ps
module acs_core_model
  import acs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // request from the sequencer
  input wire logic conv_start_i,
  input wire logic [ACS_CH_W-1:0] chan_i,
  input wire logic [1:0] group_i,
  input wire logic [1:0] ext_i,
  input wire logic [3:0] lat_i,
  // answer
  output logic conv_done_o,
  output logic [ACS_RES_W-1:0] conv_data_o
);
  logic [4:0] cnt_reg;
  logic [ACS_RES_W-1:0] pend_reg;
  ////////////////////////////////////////////////////////////////////////
  // one conversion outstanding; data lines toggle while not valid
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 5'h00;
      pend_reg <= 10'h000;
      conv_done_o <= 1'b0;
      conv_data_o <= 10'h000;
    end else begin
      conv_done_o <= 1'b0;
      conv_data_o <= ~conv_data_o;
      if (conv_start_i) begin
        cnt_reg <= {1'b0, lat_i} + 5'h01;
        if (ext_i != 2'h0) begin
          pend_reg <= {ext_i, 8'h3C};
        end else begin
          pend_reg <= {2'h0, group_i, 3'h5, chan_i};
        end
      end else if (cnt_reg == 5'h01) begin
        cnt_reg <= 5'h00;
        conv_done_o <= 1'b1;
        conv_data_o <= pend_reg;
      end else if (cnt_reg != 5'h00) begin
        cnt_reg <= cnt_reg - 5'h01;
      end
    end
  end
endmodule

// >>> tb_adc_conversion_sequencer.sv
`timescale 1ns/100ps
module tb_adc_conversion_sequencer;
  import acs_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [ACS_AW-1:0] addr = 10'h000;
  logic [ACS_DW-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic trig_n = 1'b1;
  logic [3:0] lat = 4'h0;
  logic [ACS_DW-1:0] rdata;
  logic cstart, cdone, busy, irq;
  logic ref_on, hold;
  logic [ACS_CH_W-1:0] chan;
  logic [1:0] grp, ext;
  logic [ACS_RES_W-1:0] cdata;
  logic [ACS_CH_W-1:0] seq [16];
  int fail_count = 0;
  int checks_done = 0;
  int ns = 0;
  int nirq = 0;

  acs_sequencer u_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr), .rd_en_i(rd),
    .rd_data_o(rdata), .ext_trig_n_i(trig_n), .conv_start_o(cstart),
    .chan_sel_o(chan), .group_sel_o(grp), .ext_sel_o(ext),
    .conv_done_i(cdone), .conv_data_i(cdata), .ref_connect_o(ref_on),
    .hold_en_o(hold), .busy_o(busy), .irq_o(irq));
  acs_core_model u_core (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .conv_start_i(cstart), .chan_i(chan), .group_i(grp), .ext_i(ext),
    .lat_i(lat), .conv_done_o(cdone), .conv_data_o(cdata));

  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  // log channel of the first 16 issued conversions and count every interrupt pulse
  always @(posedge sys_clk_i) begin
    if (cstart === 1'b1 && ns < 16) begin
      seq[ns] <= chan;
      ns <= ns + 1;
    end
    if (irq === 1'b1) begin
      nirq <= nirq + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk16(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] res(logic [1:0] g, logic [1:0] e, int c);
    return (e != 2'h0) ? {6'h00, e, 8'h3C} : {8'h00, g, 3'h5, 3'(c)};
  endfunction

  task automatic wreg(logic [ACS_AW-1:0] a, logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= {8'h00, d};
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rreg(logic [ACS_AW-1:0] a, logic [15:0] exp, string what);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 chk16(what, exp, rdata);
  endtask

  task automatic wait_for(int n, bit on_irq);
    int k;
    k = 0;
    while ((on_irq ? nirq : ns) < n) begin
      @(posedge sys_clk_i);
      k++;
      if (k > 600) begin
        fail_count++;
        $display("unexpected wait count exp %0d got %0d", n,
          on_irq ? nirq : ns);
        close_out();
      end
    end
  endtask

  // mode first, channel in a later write, then start
  task automatic prog(logic [7:0] c1, logic [7:0] c0);
    wreg(ACS_CTRL1_ADDR, c1);
    wreg(ACS_CTRL0_ADDR, c0 & 8'h18);
    wreg(ACS_CTRL0_ADDR, c0 & 8'h3F);
    ns = 0;
    nirq = 0;
    wreg(ACS_CTRL0_ADDR, c0);
  endtask

  task automatic stop(logic [7:0] c0);
    wreg(ACS_CTRL0_ADDR, c0);
    repeat (3) @(posedge sys_clk_i);
    chk16("busy", 16'h0000, busy);
    rreg(ACS_CTRL0_ADDR, c0, "ctrl0 after stop");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rreg(ACS_CTRL0_ADDR, 16'h0000, "ctrl0 reset");
    rreg(ACS_CTRL1_ADDR, 16'h0000, "ctrl1 reset");
    rreg(ACS_CTRL2_ADDR, 16'h0000, "ctrl2 reset");
    rreg(10'h000, 16'h0000, "unmapped");
    chk16("group", 16'h0000, grp);
    wreg(ACS_CTRL1_ADDR, 8'h20);
    repeat (40) @(posedge sys_clk_i);
    chk16("ref connect", 16'h0001, ref_on);
  endtask

  task automatic t_oneshot();
    wreg(ACS_CTRL2_ADDR, 8'h05);
    #1 chk16("hold", 16'h0001, hold);
    wreg(ACS_CTRL2_ADDR, 8'h02);
    rreg(ACS_CTRL2_ADDR, 16'h0004, "ctrl2 bad group");
    chk16("group second", 16'h0002, grp);
    prog(8'h20, 8'h45);
    wait_for(1, 1);
    chk16("oneshot count", 16'h0001, 16'(ns));
    rreg(ACS_CTRL0_ADDR, 16'h0005, "ctrl0 oneshot");
    rreg(ACS_RES_BASE + 10'h00A, res(2, 0, 5), "res5");
  endtask

  task automatic t_repeat();
    lat <= 4'h3;
    prog(8'h20, 8'h4B);
    wait_for(4, 0);
    chk16("repeat chan", 16'h0003, {13'h0000, seq[3]});
    chk16("repeat irq", 16'h0000, 16'(nirq));
    stop(8'h0B);
    rreg(ACS_RES_BASE + 10'h006, res(2, 0, 3), "res3");
    prog(8'h24, 8'h48);
    wait_for(2, 0);
    chk16("ext sel", 16'h0001, {14'h0000, ext});
    stop(8'h08);
    rreg(ACS_RES_BASE, res(2, 1, 0), "res ext");
    prog(8'h28, 8'h48);
    wait_for(2, 0);
    chk16("ext one sel", 16'h0002, {14'h0000, ext});
    stop(8'h08);
    rreg(ACS_RES_BASE + 10'h002, res(2, 2, 0), "res ext one");
  endtask

  task automatic t_sweep();
    wreg(ACS_CTRL2_ADDR, 8'h06);
    for (int s = 0; s < 4; s++) begin
      lat <= 4'(s);
      prog(8'h20 | 8'(s), 8'h50);
      wait_for(1, 1);
      repeat (4) @(posedge sys_clk_i);
      chk16("sweep count", 16'(2 * s + 2), 16'(ns));
      chk16("sweep irq", 16'h0001, 16'(nirq));
      for (int i = 0; i < 2 * s + 2; i++) begin
        chk16("sweep order", 16'(i), {13'h0000, seq[i]});
      end
      rreg(ACS_CTRL0_ADDR, 16'h0010, "ctrl0 sweep");
      rreg(ACS_RES_BASE + 10'(4 * s + 2),
        res(3, 0, 2 * s + 1), "res sweep");
    end
  endtask

  task automatic t_rsweep();
    prog(8'h21, 8'h58);
    wait_for(7, 0);
    chk16("wrap a", 16'h0000, {13'h0000, seq[4]});
    chk16("wrap b", 16'h0001, {13'h0000, seq[5]});
    chk16("rsweep irq", 16'h0000, 16'(nirq));
    stop(8'h18);
  endtask

  task automatic t_trig();
    @(posedge sys_clk_i);
    trig_n <= 1'b0;
    prog(8'h20, 8'h62);
    repeat (20) @(posedge sys_clk_i);
    chk16("early edge", 16'h0000, 16'(ns));
    trig_n <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    trig_n <= 1'b0;
    wait_for(1, 1);
    chk16("trig count", 16'h0001, 16'(ns));
    rreg(ACS_CTRL0_ADDR, 16'h0062, "ctrl0 trig");
    @(posedge sys_clk_i);
    trig_n <= 1'b1;
    stop(8'h22);
  endtask

  // reset in the middle of a running repeat conversion
  task automatic t_midreset();
    prog(8'h20, 8'h4B);
    wait_for(2, 0);
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    chk16("busy after reset", 16'h0000, busy);
    chk16("group after reset", 16'h0000, grp);
    rreg(ACS_CTRL0_ADDR, 16'h0000, "ctrl0 after reset");
    rreg(ACS_CTRL1_ADDR, 16'h0000, "ctrl1 after reset");
  endtask

  initial begin
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_oneshot();
    t_repeat();
    t_sweep();
    t_rsweep();
    t_trig();
    t_midreset();
    close_out();
  end
endmodule
